// file: verilog/cmwd_regs.svh
// register offsets, field positions, reset values, service keys and interrupt bits
// assumes inclusion from the design file only
`ifndef CMWD_REGS_SVH
`define CMWD_REGS_SVH

`define CMWD_ADDR_W 8
`define CMWD_OFF_WDCTL 8'h0C
`define CMWD_OFF_MODE 8'h10
`define CMWD_OFF_STAT 8'h14
`define CMWD_OFF_IRQST 8'h18
`define CMWD_OFF_IRQMSK 8'h1C
`define CMWD_OFF_SERVICE 8'h20
`define CMWD_BIT_WIN 7
`define CMWD_BIT_DBG 6
`define CMWD_BIT_WMASK 5
`define CMWD_BIT_SEL1 1
`define CMWD_BIT_SEL0 0
`define CMWD_BIT_PSTOPCE 2
`define CMWD_POSTDIV_RST 8'h03
`define CMWD_VCO_MHZ 50
`define CMWD_SERVICE_KEY1 8'h55
`define CMWD_SERVICE_KEY2 8'hAA
`define CMWD_IRQ_TIMEOUT 0
`define CMWD_IRQ_RESTART 1
`define CMWD_IRQ_OSCLOSS 2

`endif

// file: verilog/cmwd_pkg.sv
// types shared by the clock mode and watchdog control block
// assumes the _regs header supplies the numeric constants
package cmwd_pkg;
    typedef enum logic [1:0] {
        CLK_INT_PLL,
        CLK_EXT_PLL,
        CLK_BYPASS_EXT
    } cmwd_clkmode_e;

    typedef enum logic [1:0] {
        WSRC_AUX,
        WSRC_IRC,
        WSRC_OSC
    } cmwd_wsrc_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cmwd_bus_s;

    typedef struct packed {
        logic window;
        logic runDebug;
        logic writeMask;
        logic [2:0] rate;
    } cmwd_ctl_s;
endpackage

// file: verilog/cmwd_clock_mode_ctl.sv
// clock mode selection and watchdog control, one clock domain
// assumes clock-enable ticks for the three watchdog sources and flash data at reset release
// Functional notes
// RQ1 - after any reset the internal-reference PLL engaged mode is selected
// RQ2 - reset PLL setup: 50 MHz core, post divider 3, bus is half PLL output
// RQ3 - internal mode feeds PLL reference from the internal 1 MHz oscillator
// RQ4 - run mode keeps PLL, internal oscillator, periodic interrupt on, regulator full
// RQ5 - software configures PLL, divider, oscillator, then waits for up and lock
// RQ6 - bypass mode takes bus clock from oscillator while the PLL stays running
// RQ7 - two select bits choose auxiliary, internal or oscillator watchdog clock
// RQ8 - with select1 clear, pseudo stop counts only with select0 set and enable set
// RQ9 - with select1 set the watchdog counts in full and pseudo stop
// RQ10 - debug-run bit writable freely in special mode, only settable in normal mode
// RQ11 - window and rate writes need mask clear; once in normal, unlimited special
// RQ12 - in normal mode zero writes keep value yet consume the single write
// RQ13 - non-zero flash rate starts the time-out right after reset
// RQ14 - select bit change or oscillator loss with select 01 restarts time-out
// RQ15 - normal mode restarts on accepted rate or window write, or debug set
// RQ16 - in special mode every control register write restarts time-out
// RQ17 - control register reloads from flash after reset, readable anytime
// RQ18 - window bit 7, debug bit 6, mask bit 5, rate bits 2 to 0
// RQ19 - time-out without restart raises a watchdog reset request
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "cmwd_regs.svh"

module cmwd_clock_mode_ctl (
    input wire logic clk, // 10 MHz bus clock
    input wire logic rst_n, // synchronous reset, active low
    input wire cmwd_pkg::cmwd_bus_s bus, // register access request
    output logic [7:0] rdata, // read data, cycle after read strobe
    input wire logic [7:0] flashCtl, // flash image of the control register
    input wire logic specialMode, // special mode when high
    input wire logic stopMode, // stop mode active
    input wire logic pseudoStop, // stop is pseudo stop
    input wire logic auxTick, // auxiliary clock enable pulse
    input wire logic ircTick, // internal reference clock enable pulse
    input wire logic oscTick, // oscillator clock enable pulse
    input wire logic oscUp, // oscillator up status
    input wire logic pllLock, // PLL lock status
    output logic [1:0] clkMode, // selected clock mode
    output logic pllRefFromOsc, // PLL reference from oscillator
    output logic busFromOsc, // bus clock from oscillator
    output logic pllOn, // PLL running
    output logic ircOn, // internal reference running
    output logic apiAvail, // periodic interrupt available
    output logic regFull, // regulator full performance
    output logic oscEnable, // external oscillator enable
    output logic [3:0] refDivider, // reference divider
    output logic [7:0] postDivider, // PLL post divider
    output logic [1:0] wdogSource, // watchdog clock source
    output logic wdogReset, // watchdog reset request
    output logic irq // level interrupt
);
    // timeout length per rate: 2^(8+2*rate) source ticks
    localparam int CNT_W = 24;

    cmwd_pkg::cmwd_ctl_s ctl;
    logic sel0, sel1, pstopCe, onceUsed, loadPend, oscUpQ, running;
    logic [1:0] modeReg;
    logic [CNT_W-1:0] count;
    logic [2:0] irqStat, irqMask;
    logic [7:0] svcState;

    wire wrCtl = bus.wr && bus.addr == `CMWD_OFF_WDCTL;
    wire wrMode = bus.wr && bus.addr == `CMWD_OFF_MODE;
    wire wrIrqSt = bus.wr && bus.addr == `CMWD_OFF_IRQST;
    wire wrMsk = bus.wr && bus.addr == `CMWD_OFF_IRQMSK;
    wire wrSvc = bus.wr && bus.addr == `CMWD_OFF_SERVICE;
    wire [7:0] wd = bus.wdata;
    // window, rate writable while mask is clear and once-budget remains
    wire protOk = !ctl.writeMask && (specialMode || !onceUsed); // RQ11
    wire rateAcc = wrCtl && protOk && (specialMode || wd[2:0] != 3'h0); // RQ12
    wire winAcc = wrCtl && protOk && (specialMode || wd[`CMWD_BIT_WIN]); // RQ12
    wire dbgNext = specialMode ? wd[`CMWD_BIT_DBG] : (ctl.runDebug | wd[`CMWD_BIT_DBG]); // RQ10
    wire selChg = wrMode && (wd[`CMWD_BIT_SEL0] != sel0 || wd[`CMWD_BIT_SEL1] != sel1); // RQ14
    wire oscLost = oscUpQ && !oscUp && !sel1 && sel0; // RQ14
    wire normRst = wrCtl && protOk && (wd[2:0] != 3'h0 || wd[`CMWD_BIT_WIN]); // RQ15
    wire dbgRise = wrCtl && !ctl.runDebug && wd[`CMWD_BIT_DBG]; // RQ15
    // special mode restarts on any control write, normal mode only on accepted changes
    wire specRst = specialMode && wrCtl; // RQ16
    wire normPath = !specialMode && (normRst || dbgRise); // RQ15
    // the flash reload counts as a restart so a non-zero rate starts at once
    wire restart = selChg || oscLost || specRst || normPath || loadPend; // RQ13
    wire srcTick = sel1 ? oscTick : (sel0 ? ircTick : auxTick); // RQ7
    // stop gating: select1 keeps counting; pseudo stop with 01 and enable too
    wire canRun = !stopMode || sel1 || (pseudoStop && sel0 && pstopCe); // RQ8 RQ9
    wire [CNT_W-1:0] limit = CNT_W'(1) << (5'd8 + {1'b0, ctl.rate, 1'b0});
    wire expire = running && ctl.rate != 3'h0 && canRun && srcTick && count >= limit - 1'b1;
    wire svcKick = wrSvc && wd == `CMWD_SERVICE_KEY2 && svcState == `CMWD_SERVICE_KEY1;
    wire [2:0] irqSet = {oscLost, restart, expire};
    wire [7:0] ctlByte = {ctl.window, ctl.runDebug, ctl.writeMask, 2'b00, ctl.rate}; // RQ18
    wire [7:0] modeByte = {3'h0, oscEnable, 1'b0, pstopCe, sel1, sel0};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl <= '0;
            loadPend <= 1'b1;
            onceUsed <= 1'b0;
        end else if (loadPend) begin
            ctl <= {flashCtl[7], flashCtl[6], flashCtl[5], flashCtl[2:0]}; // RQ17
            loadPend <= 1'b0;
        end else if (wrCtl) begin
            ctl.runDebug <= dbgNext; // RQ10
            if (rateAcc) ctl.rate <= wd[2:0]; // RQ11
            if (winAcc) ctl.window <= wd[`CMWD_BIT_WIN];
            if (protOk && !specialMode) onceUsed <= 1'b1; // RQ12
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            modeReg <= cmwd_pkg::CLK_INT_PLL; // RQ1
            sel0 <= 1'b0;
            sel1 <= 1'b0;
            pstopCe <= 1'b0;
            oscEnable <= 1'b0;
            refDivider <= 4'h0;
        end else if (wrMode) begin
            sel0 <= wd[`CMWD_BIT_SEL0];
            sel1 <= wd[`CMWD_BIT_SEL1];
            pstopCe <= wd[`CMWD_BIT_PSTOPCE];
            oscEnable <= wd[4];
            // external modes need an enabled, running oscillator and PLL lock; keep the current mode otherwise
            if (wd[7:6] != 2'h0 && wd[4] && oscUp && pllLock) // RQ5
                modeReg <= (wd[7:6] == 2'h1) ? cmwd_pkg::CLK_EXT_PLL : cmwd_pkg::CLK_BYPASS_EXT;
            else if (wd[7:6] == 2'h0)
                modeReg <= cmwd_pkg::CLK_INT_PLL;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= '0;
            running <= 1'b0;
            oscUpQ <= 1'b0;
            wdogReset <= 1'b0;
            svcState <= 8'h00;
        end else begin
            oscUpQ <= oscUp;
            if (wrSvc) svcState <= wd;
            if (restart || svcKick) begin
                count <= '0;
                running <= loadPend ? (flashCtl[2:0] != 3'h0) : 1'b1; // RQ13
            end else if (running && canRun && srcTick) begin
                count <= expire ? '0 : count + 1'b1;
            end
            if (expire) wdogReset <= 1'b1; // RQ19
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irqStat <= 3'h0;
            irqMask <= 3'h0;
            irq <= 1'b0;
        end else begin
            // a new event wins over a same-cycle write-one clear
            irqStat <= (irqStat & ~(wrIrqSt ? wd[2:0] : 3'h0)) | irqSet;
            if (wrMsk) irqMask <= wd[2:0];
            // a set mask bit hides its status bit from the interrupt line
            irq <= |((irqStat | irqSet) & ~(wrMsk ? wd[2:0] : irqMask));
        end
    end

    wire [7:0] rdMux = (bus.addr == `CMWD_OFF_WDCTL) ? ctlByte :
        (bus.addr == `CMWD_OFF_MODE) ? {modeReg, modeByte[5:0]} :
        (bus.addr == `CMWD_OFF_STAT) ? {4'h0, running, wdogReset, pllLock, oscUp} :
        (bus.addr == `CMWD_OFF_IRQST) ? {5'h00, irqStat} :
        (bus.addr == `CMWD_OFF_IRQMSK) ? {5'h00, irqMask} : 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
            clkMode <= cmwd_pkg::CLK_INT_PLL;
            pllRefFromOsc <= 1'b0;
            busFromOsc <= 1'b0;
            pllOn <= 1'b1;
            ircOn <= 1'b1;
            apiAvail <= 1'b1;
            regFull <= 1'b1;
            postDivider <= `CMWD_POSTDIV_RST; // RQ2
            wdogSource <= cmwd_pkg::WSRC_AUX;
        end else begin
            rdata <= bus.rd ? rdMux : 8'h00; // RQ17
            clkMode <= modeReg;
            pllRefFromOsc <= modeReg != cmwd_pkg::CLK_INT_PLL; // RQ3
            busFromOsc <= modeReg == cmwd_pkg::CLK_BYPASS_EXT; // RQ6
            pllOn <= 1'b1; // RQ4 RQ6
            ircOn <= 1'b1;
            apiAvail <= 1'b1;
            regFull <= !stopMode;
            postDivider <= `CMWD_POSTDIV_RST;
            wdogSource <= sel1 ? cmwd_pkg::WSRC_OSC : (sel0 ? cmwd_pkg::WSRC_IRC : cmwd_pkg::WSRC_AUX);
        end
    end

    property p_rst_mode;
        @(posedge clk) $rose(rst_n) |=> clkMode == cmwd_pkg::CLK_INT_PLL;
    endproperty
    a_rst_mode: assert property (p_rst_mode) else $error("mode not internal after reset"); // RQ1
    property p_ref;
        @(posedge clk) disable iff (!rst_n) clkMode == cmwd_pkg::CLK_INT_PLL |-> !pllRefFromOsc;
    endproperty
    a_ref: assert property (p_ref) else $error("reference not internal"); // RQ3
    property p_stop_halt;
        @(posedge clk) disable iff (!rst_n) stopMode && !sel1 && !(pseudoStop && sel0 && pstopCe)
            && !restart && !svcKick |=> $stable(count);
    endproperty
    a_stop_halt: assert property (p_stop_halt) else $error("count moved in stop"); // RQ8
    property p_dbg_norm;
        @(posedge clk) disable iff (!rst_n) !specialMode && ctl.runDebug && !loadPend |=> ctl.runDebug;
    endproperty
    a_dbg_norm: assert property (p_dbg_norm) else $error("debug bit cleared in normal"); // RQ10
    property p_mask;
        @(posedge clk) disable iff (!rst_n) wrCtl && ctl.writeMask && !loadPend |=> $stable(ctl.rate);
    endproperty
    a_mask: assert property (p_mask) else $error("rate changed under mask"); // RQ11
    property p_once;
        @(posedge clk) disable iff (!rst_n) onceUsed && !specialMode && !loadPend
            |=> $stable(ctl.rate) && $stable(ctl.window);
    endproperty
    a_once: assert property (p_once) else $error("second normal write took"); // RQ12
    property p_spec_restart;
        @(posedge clk) disable iff (!rst_n) wrCtl && specialMode && !loadPend |=> count == 0;
    endproperty
    a_spec_restart: assert property (p_spec_restart) else $error("no restart on write"); // RQ16
    property p_sel_restart;
        @(posedge clk) disable iff (!rst_n) selChg |=> count == 0 && running;
    endproperty
    a_sel_restart: assert property (p_sel_restart) else $error("no restart on select"); // RQ14
    property p_expire;
        @(posedge clk) disable iff (!rst_n) expire && !restart |=> wdogReset;
    endproperty
    a_expire: assert property (p_expire) else $error("no reset on timeout"); // RQ19

    // flash reload, start of the time-out and the clock and power outputs
    property p_reload;
        @(posedge clk) disable iff (!rst_n)
            loadPend |=> ctl == $past({flashCtl[7:5], flashCtl[2:0]});
    endproperty
    a_reload: assert property (p_reload) else $error("control not reloaded"); // RQ17

    property p_rate_start;
        @(posedge clk) disable iff (!rst_n)
            loadPend |=> running == ($past(flashCtl[2:0]) != 3'h0);
    endproperty
    a_rate_start: assert property (p_rate_start) else $error("flash rate did not start"); // RQ13

    property p_postdiv;
        @(posedge clk) disable iff (!rst_n)
            1'b1 |-> postDivider == `CMWD_POSTDIV_RST;
    endproperty
    a_postdiv: assert property (p_postdiv) else $error("post divider moved"); // RQ2

    property p_run_on;
        @(posedge clk) disable iff (!rst_n)
            !stopMode |=> regFull && pllOn && ircOn && apiAvail;
    endproperty
    a_run_on: assert property (p_run_on) else $error("run mode resource off"); // RQ4

    property p_clk_follow;
        @(posedge clk) disable iff (!rst_n)
            1'b1 |=> clkMode == $past(modeReg);
    endproperty
    a_clk_follow: assert property (p_clk_follow) else $error("mode output lags"); // RQ1

    property p_bypass;
        @(posedge clk) disable iff (!rst_n)
            clkMode == cmwd_pkg::CLK_BYPASS_EXT |-> busFromOsc && pllOn && pllRefFromOsc;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass clocking wrong"); // RQ6

    property p_src;
        @(posedge clk) disable iff (!rst_n)
            1'b1 |=> wdogSource == $past(sel1 ? 2'h2 : {1'b0, sel0});
    endproperty
    a_src: assert property (p_src) else $error("watchdog source wrong"); // RQ7

    // switching to an external mode needs the oscillator enabled and up and the lock, else it is refused
    sequence s_mode_refused;
        wrMode && wd[7:6] != 2'h0 && !(wd[4] && oscUp && pllLock);
    endsequence

    property p_mode_refused;
        @(posedge clk) disable iff (!rst_n)
            s_mode_refused |=> $stable(modeReg);
    endproperty
    a_mode_refused: assert property (p_mode_refused) else $error("mode taken early"); // RQ5

    sequence s_mode_accept;
        wrMode && wd[7:6] == 2'h1 && wd[4] && oscUp && pllLock;
    endsequence

    property p_mode_accept;
        @(posedge clk) disable iff (!rst_n)
            s_mode_accept |=> modeReg == cmwd_pkg::CLK_EXT_PLL;
    endproperty
    a_mode_accept: assert property (p_mode_accept) else $error("external mode refused"); // RQ5

    property p_mode_int;
        @(posedge clk) disable iff (!rst_n)
            wrMode && wd[7:6] == 2'h0 |=> modeReg == cmwd_pkg::CLK_INT_PLL;
    endproperty
    a_mode_int: assert property (p_mode_int) else $error("internal mode refused"); // RQ1

    // restart sources and control write rules
    sequence s_osc_drop;
        oscUpQ && !oscUp && !sel1 && sel0;
    endsequence

    property p_osc_restart;
        @(posedge clk) disable iff (!rst_n)
            s_osc_drop |=> count == '0 && running;
    endproperty
    a_osc_restart: assert property (p_osc_restart) else $error("no restart on loss"); // RQ14

    property p_norm_restart;
        @(posedge clk) disable iff (!rst_n)
            !specialMode && !loadPend && (normRst || dbgRise) |=> count == '0 && running;
    endproperty
    a_norm_restart: assert property (p_norm_restart) else $error("no normal restart"); // RQ15

    property p_dbg_spec;
        @(posedge clk) disable iff (!rst_n)
            wrCtl && specialMode && !loadPend |=> ctl.runDebug == $past(wd[`CMWD_BIT_DBG]);
    endproperty
    a_dbg_spec: assert property (p_dbg_spec) else $error("debug bit not written"); // RQ10

    property p_rate_zero;
        @(posedge clk) disable iff (!rst_n)
            wrCtl && !specialMode && !loadPend && wd[2:0] == 3'h0 |=> $stable(ctl.rate);
    endproperty
    a_rate_zero: assert property (p_rate_zero) else $error("zero rate taken"); // RQ12

    property p_win_zero;
        @(posedge clk) disable iff (!rst_n)
            wrCtl && !specialMode && !loadPend && !wd[`CMWD_BIT_WIN] |=> $stable(ctl.window);
    endproperty
    a_win_zero: assert property (p_win_zero) else $error("zero window taken"); // RQ12

    property p_once_used;
        @(posedge clk) disable iff (!rst_n)
            wrCtl && !specialMode && !loadPend && protOk |=> onceUsed;
    endproperty
    a_once_used: assert property (p_once_used) else $error("write budget kept"); // RQ12

    // counting in the stop modes
    sequence s_pseudo_count;
        stopMode && pseudoStop && sel0 && !sel1 && pstopCe && running && srcTick;
    endsequence

    property p_pseudo_run;
        @(posedge clk) disable iff (!rst_n)
            s_pseudo_count ##0 (!restart && !svcKick && !expire)
            |=> count == $past(count) + CNT_W'(1);
    endproperty
    a_pseudo_run: assert property (p_pseudo_run) else $error("pseudo stop halted"); // RQ8

    sequence s_sel1_count;
        stopMode && sel1 && running && srcTick;
    endsequence

    property p_full_run;
        @(posedge clk) disable iff (!rst_n)
            s_sel1_count ##0 (!restart && !svcKick && !expire)
            |=> count == $past(count) + CNT_W'(1);
    endproperty
    a_full_run: assert property (p_full_run) else $error("stop halted select1"); // RQ9

    // service, reset request, read port and status
    property p_svc_restart;
        @(posedge clk) disable iff (!rst_n)
            svcKick && !loadPend |=> count == '0 && running;
    endproperty
    a_svc_restart: assert property (p_svc_restart) else $error("no restart on service"); // RQ19

    property p_wdog_sticky;
        @(posedge clk) disable iff (!rst_n)
            wdogReset |=> wdogReset;
    endproperty
    a_wdog_sticky: assert property (p_wdog_sticky) else $error("reset request dropped"); // RQ19

    property p_rdata_idle;
        @(posedge clk) disable iff (!rst_n)
            !bus.rd |=> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read"); // RQ17

    property p_irq_sticky;
        @(posedge clk) disable iff (!rst_n)
            irqStat[`CMWD_IRQ_TIMEOUT] && !(wrIrqSt && wd[`CMWD_IRQ_TIMEOUT])
            |=> irqStat[`CMWD_IRQ_TIMEOUT];
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("timeout flag lost"); // RQ19
endmodule
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the clock mode and watchdog control block
// assumes the design package and header compile first; one 10 MHz clock
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    cmwd_pkg::cmwd_bus_s bus = '0;
    logic [7:0] flashCtl = 8'h00;
    logic specialMode = 1'b0;
    logic stopMode = 1'b0;
    logic pseudoStop = 1'b0;
    logic tick = 1'b1;
    logic oscUp = 1'b1;
    logic pllLock = 1'b1;
    logic [7:0] rdata, postDivider, f;
    logic [1:0] clkMode, wdogSource;
    logic [3:0] refDivider;
    logic pllRefFromOsc, busFromOsc, pllOn, ircOn, apiAvail, regFull, oscEnable, wdogReset, irq;
    logic rdPend = 1'b0;
    logic [7:0] expQ[$];
    integer seed = 60860;
    integer miscompares = 0;
    integer num_checks = 0;
    integer n;

    always #50 clk = ~clk;

    cmwd_clock_mode_ctl uut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .flashCtl(flashCtl), .specialMode(specialMode), .stopMode(stopMode),
        .pseudoStop(pseudoStop), .auxTick(tick), .ircTick(tick), .oscTick(tick),
        .oscUp(oscUp), .pllLock(pllLock), .clkMode(clkMode), .pllRefFromOsc(pllRefFromOsc),
        .busFromOsc(busFromOsc), .pllOn(pllOn), .ircOn(ircOn), .apiAvail(apiAvail),
        .regFull(regFull), .oscEnable(oscEnable), .refDivider(refDivider),
        .postDivider(postDivider), .wdogSource(wdogSource), .wdogReset(wdogReset), .irq(irq));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // read data is noted by the driver and compared here in the cycle after the strobe
    always @(posedge clk) begin
        if (rdPend) begin
            chk("rdata", expQ.pop_front(), rdata);
        end
        rdPend <= bus.rd;
    end

    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
        @(posedge clk);
        bus <= '{a, d, w, r};
        @(posedge clk);
        bus <= '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(a, d, 1'b1, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        expQ.push_back(exp);
        acc(a, 8'h00, 1'b0, 1'b1);
    endtask

    task automatic settle;
        @(posedge clk);
        #1;
    endtask

    task automatic reset_dut(input logic [7:0] flash, input logic spec, input string name);
        $display("test %s", name);
        @(posedge clk);
        rst_n <= 1'b0;
        flashCtl <= flash;
        specialMode <= spec;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask

    // a bound that runs out where a time-out was due ends the run
    task automatic wdog_wait(input int lo, input int hi, input logic fire);
        for (n = 0; n < hi && wdogReset !== 1'b1; n++) @(posedge clk);
        chk("wdogReset", {7'h00, fire}, {7'h00, n >= lo && n < hi});
        if (fire && n >= hi) conclude();
    endtask

    initial begin
        f = (8'($random(seed)) & 8'h80) | 8'h03;
        reset_dut(f, 1'b0, "reset and write once");
        settle();
        chk("clkMode", 8'h00, {6'h00, clkMode});
        chk("postDivider", 8'h03, postDivider);
        chk("clocks", 8'h0F, {2'b00, pllRefFromOsc, busFromOsc, pllOn, ircOn, apiAvail, regFull});
        chk("refDivider", 8'h00, {4'h0, refDivider});
        rd(8'h0C, f);
        wr(8'h0C, 8'h05);
        rd(8'h0C, (f & 8'h80) | 8'h05);
        wr(8'h0C, 8'h82);
        rd(8'h0C, (f & 8'h80) | 8'h05);
        wr(8'h0C, 8'h40);
        wr(8'h0C, 8'h00);
        rd(8'h0C, (f & 8'h80) | 8'h45);
        rd(8'h30, 8'h00);
        pllLock <= 1'b0;
        wr(8'h10, 8'h10);
        wr(8'h10, 8'h50);
        settle();
        chk("refused mode", 8'h01, {6'h00, clkMode, 1'b0} | {7'h00, oscEnable});
        pllLock <= 1'b1;
        wr(8'h10, 8'h50);
        settle();
        chk("ext mode", 8'h03, {5'h00, clkMode, pllRefFromOsc});
        wr(8'h10, 8'h90);
        settle();
        chk("bypass", 8'h0B, {4'h0, clkMode, busFromOsc, pllOn});
        reset_dut(8'h01, 1'b0, "timeout and interrupt");
        wdog_wait(1000, 1040, 1'b1);
        tick <= 1'b0;
        wr(8'h1C, 8'h00);
        settle();
        chk("irq raised", 8'h01, {7'h00, irq});
        wr(8'h1C, 8'h07);
        settle();
        chk("irq masked", 8'h00, {7'h00, irq});
        wr(8'h1C, 8'h00);
        wr(8'h18, 8'h07);
        settle();
        chk("irq cleared", 8'h00, {7'h00, irq});
        rd(8'h18, 8'h00);
        wr(8'h0C, 8'h00);
        wr(8'h0C, 8'h06);
        rd(8'h0C, 8'h01);
        tick <= 1'b1;
        reset_dut(8'h01, 1'b1, "special mode");
        repeat (600) @(posedge clk);
        wr(8'h0C, 8'h01);
        wdog_wait(0, 400, 1'b0);
        wdog_wait(580, 660, 1'b1);
        wr(8'h0C, 8'h06);
        wr(8'h0C, 8'h42);
        rd(8'h0C, 8'h42);
        wr(8'h0C, 8'h00);
        rd(8'h0C, 8'h00);
        reset_dut(8'h21, 1'b1, "write mask");
        wr(8'h0C, 8'h25);
        rd(8'h0C, 8'h21);
        reset_dut(8'h01, 1'b0, "full stop");
        stopMode <= 1'b1;
        wdog_wait(0, 1100, 1'b0);
        chk("regFull", 8'h00, {7'h00, regFull});
        wr(8'h10, 8'h02);
        wdog_wait(1000, 1040, 1'b1);
        chk("wdogSource", 8'h02, {6'h00, wdogSource});
        reset_dut(8'h01, 1'b0, "pseudo stop");
        pseudoStop <= 1'b1;
        wr(8'h10, 8'h05);
        repeat (500) @(posedge clk);
        oscUp <= 1'b0;
        wdog_wait(1000, 1040, 1'b1);
        oscUp <= 1'b1;
        reset_dut(8'h01, 1'b0, "pseudo stop halted");
        wr(8'h10, 8'h01);
        wdog_wait(0, 1100, 1'b0);
        repeat (3) @(posedge clk);
        conclude();
    end
endmodule
`default_nettype wire
